// >>> sim/spb_cmd_top_tb.sv
// Self-checking bench for the security packet command sequencer
`timescale 1ns/1ps
module spb_cmd_top_tb import spb_pkg::*; ;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        tf_wr = 1'b0;
  logic        tf_rd = 1'b0;
  logic [2:0]  tf_addr = 3'h0;
  logic [15:0] tf_wdata = 16'h0000;
  logic        dmack = 1'b0;
  logic [15:0] dma_wdata = 16'h0000;
  logic        stall = 1'b0;
  logic [15:0] tf_rdata, dma_rdata, rx_data, tx_data, tx_count;
  logic        intrq, dmarq, sec_start, sec_send, irq_prev = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready;
  logic [7:0]  sec_protocol;
  logic [23:0] sec_args;
  logic [31:0] tx_sum;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  int irq_edges = 0;
  int dmarq_cnt = 0;
  int irq0, dmq0;

  spb_cmd_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .tf_wr(tf_wr),
    .tf_rd(tf_rd), .tf_addr(tf_addr), .tf_wdata(tf_wdata),
    .tf_rdata(tf_rdata), .intrq(intrq), .dmarq(dmarq), .dmack(dmack),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .sec_start(sec_start),
    .sec_send(sec_send), .sec_protocol(sec_protocol), .sec_args(sec_args),
    .sec_rx_data(rx_data), .sec_rx_valid(rx_valid),
    .sec_rx_ready(rx_ready), .sec_tx_data(tx_data),
    .sec_tx_valid(tx_valid), .sec_tx_ready(tx_ready));
  spb_engine_model engine (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .stall(stall), .sec_start(sec_start), .sec_send(sec_send),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_count(tx_count), .tx_sum(tx_sum));

  always #4 sys_clk = ~sys_clk;
  // Interrupt edges, request cycles and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    irq_prev <= intrq;
    if (intrq === 1'b1 && irq_prev !== 1'b1) irq_edges <= irq_edges + 1;
    if (dmarq === 1'b1) dmarq_cnt <= dmarq_cnt + 1;
    if (cycles == 40000) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: run hung", $time);
      end_sim;
    end
  end

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk_bit(input logic g, input logic e, input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %b", $time, m, g);
    end
  endtask
  task automatic chk_val(input logic [31:0] g, e, input string m);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  function automatic logic [15:0] pat(input int k);
    return 16'hc300 ^ k[15:0];
  endfunction
  // Taskfile accesses: strobe for one edge, then a quiet edge
  task automatic tf_write(input logic [2:0] a, input logic [15:0] d);
    tf_wr <= 1'b1;
    tf_addr <= a;
    tf_wdata <= d;
    @(posedge sys_clk);
    tf_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic tf_read(input logic [2:0] a, output logic [15:0] d);
    tf_rd <= 1'b1;
    tf_addr <= a;
    @(posedge sys_clk);
    tf_rd <= 1'b0;
    #1 d = tf_rdata;
    @(posedge sys_clk);
  endtask
  task automatic wait_drq;
    logic [15:0] s;
    s = 16'h0000;
    for (int n = 0; n < 200 && s[ST_DRQ_BIT] !== 1'b1; n++)
      tf_read(TF_CMDST, s);
  endtask
  task automatic start_cmd(input logic [7:0] op, ft, cnt, input logic sec);
    tf_write(TF_ERRFT, {8'h00, ft});
    tf_write(TF_COUNT, {8'h00, cnt});
    tf_write(TF_SECNUM, 16'h0011);
    tf_write(TF_CYLLO, 16'h0022);
    tf_write(TF_CYLHI, 16'h0033);
    irq0 = irq_edges;
    dmq0 = dmarq_cnt;
    tf_wr <= 1'b1;
    tf_addr <= TF_CMDST;
    tf_wdata <= {8'h00, op};
    @(posedge sys_clk);
    tf_wr <= 1'b0;
    #1;
    if (sec) begin
      chk_bit(sec_start, 1'b1, "start pulse");
      chk_bit(sec_send, op != OP_SEC_RX_DMA, "direction");
      chk_val(sec_protocol, ft, "protocol");
      chk_val(sec_args, 24'h332211, "arguments");
    end
    @(posedge sys_clk);
  endtask
  task automatic finish_cmd(input logic [7:0] st, er);
    logic [15:0] w;
    for (int n = 0; n < 2000 && intrq !== 1'b1; n++) @(posedge sys_clk);
    tf_read(TF_CMDST, w);
    chk_val(w[7:0] & 8'hef, st, "status");
    tf_read(TF_ERRFT, w);
    chk_val(w[7:0], er, "error");
    tf_read(TF_COUNT, w);
    chk_val(w, 16'h0000, "count after end");
    chk_bit(intrq, 1'b0, "interrupt cleared");
    chk_val(irq_edges - irq0, 1, "interrupt count");
  endtask
  // PIO packet send or buffer load, word by word while DRQ
  task automatic pio_out(input logic [7:0] op, ft, cnt);
    logic [31:0] sum;
    sum = 32'h0;
    start_cmd(op, ft, cnt, op == OP_SEC_TX_PIO);
    for (int k = 0; k < cnt * 256; k++) begin
      wait_drq;
      tf_write(TF_DATA, pat(k));
      sum += pat(k);
    end
    finish_cmd(8'h40, 8'h00);
    if (op == OP_SEC_TX_PIO) begin
      chk_val(tx_count, cnt * 256, "words to engine");
      chk_val(tx_sum, sum, "word sum");
    end
  endtask
  task automatic buf_check;
    logic [15:0] w;
    pio_out(OP_BUF_LOAD, 8'h00, 8'h01);
    start_cmd(OP_BUF_READ, 8'h00, 8'h01, 1'b0);
    for (int k = 0; k < 256; k++) begin
      wait_drq;
      tf_read(TF_DATA, w);
      chk_val(w, pat(k), "buffer word");
    end
    finish_cmd(8'h40, 8'h00);
  endtask
  // DMA packet send: each take is an edge with dmarq and dmack high
  task automatic dma_send(input logic [7:0] ft, cnt);
    logic [31:0] sum;
    int n;
    sum = 32'h0;
    n = 0;
    dma_wdata <= pat(0);
    start_cmd(OP_SEC_TX_DMA, ft, cnt, 1'b1);
    dmack <= 1'b1;
    for (int t = 0; t < 5000 && n < cnt * 256; t++) begin
      @(posedge sys_clk);
      if (dmarq === 1'b1) begin
        sum += pat(n);
        n++;
        dma_wdata <= pat(n);
      end
    end
    dmack <= 1'b0;
    finish_cmd(8'h40, 8'h00);
    chk_val(tx_count, cnt * 256, "dma words to engine");
    chk_val(tx_sum, sum, "dma word sum");
  endtask
  task automatic dma_recv(input logic [7:0] ft, cnt);
    int n;
    n = 0;
    start_cmd(OP_SEC_RX_DMA, ft, cnt, 1'b1);
    dmack <= 1'b1;
    for (int t = 0; t < 9000 && n < cnt * 256; t++) begin
      @(posedge sys_clk);
      if (dmarq === 1'b1) begin
        chk_val(dma_rdata, n[15:0] ^ 16'h5a5a, "packet word");
        n++;
      end
    end
    dmack <= 1'b0;
    finish_cmd(8'h40, 8'h00);
    chk_bit(dmarq, 1'b0, "request dropped");
  endtask
  // Bad protocol, zero count and unknown opcode all abort
  task automatic aborts;
    logic [7:0] ops [3] = '{OP_SEC_TX_DMA, OP_SEC_RX_DMA, 8'h77};
    logic [7:0] fts [3] = '{8'h03, 8'h00, 8'h00};
    logic [7:0] cns [3] = '{8'h01, 8'h00, 8'h01};
    for (int i = 0; i < 3; i++) begin
      start_cmd(ops[i], fts[i], cns[i], 1'b0);
      finish_cmd(8'h41, 8'h04);
      chk_val(dmarq_cnt - dmq0, 0, "no data phase");
    end
  endtask

  // Main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    stall <= 1'b1;
    @(posedge sys_clk);
    dma_recv(8'h00, 8'h02);
    dma_send(8'h01, 8'h01);
    pio_out(OP_SEC_TX_PIO, 8'h02, 8'h02);
    stall <= 1'b0;
    buf_check;
    aborts;
    end_sim;
  end
endmodule // spb_cmd_top_tb

// >>> sim/spb_engine_model.sv
// Behavioural security engine facing the command sequencer
`timescale 1ns/1ps
module spb_engine_model (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        stall,
  input  wire logic        sec_start,
  input  wire logic        sec_send,
  output logic      [15:0] rx_data,
  output logic             rx_valid,
  input  wire logic        rx_ready,
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic      [15:0] tx_count,
  output logic      [31:0] tx_sum
);
  logic [15:0] idx_reg;
  logic [1:0]  tick_reg;
  logic        on_reg;
  // Slow mode offers a handshake one cycle in four
  assign rx_valid = on_reg & ~sec_send & (~stall | (tick_reg == 2'h0));
  assign rx_data  = rx_valid ? (idx_reg ^ 16'h5a5a)
                             : ~((idx_reg - 16'h0001) ^ 16'h5a5a);
  assign tx_ready = ~stall | (tick_reg == 2'h0);
  // Packet source index and sink tally, restarted per command
  always @(posedge sys_clk) begin
    tick_reg <= tick_reg + 2'h1;
    if (sys_rst) begin
      tick_reg <= 2'h0;
      idx_reg  <= 16'h0000;
      on_reg   <= 1'b0;
      tx_count <= 16'h0000;
      tx_sum   <= 32'h0;
    end else if (sec_start) begin
      idx_reg  <= 16'h0000;
      on_reg   <= 1'b1;
      tx_count <= 16'h0000;
      tx_sum   <= 32'h0;
    end else begin
      if (rx_valid & rx_ready)
        idx_reg <= idx_reg + 16'h0001;
      if (tx_valid & tx_ready) begin
        tx_count <= tx_count + 16'h0001;
        tx_sum   <= tx_sum + {16'h0000, tx_data};
      end
    end
  end
endmodule // spb_engine_model

// >>> verilog/spb_cmd_top.sv
// Security packet and buffer load command sequencer behind the taskfile
`timescale 1ns/1ps
module spb_cmd_top import spb_pkg::*; (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        tf_wr,
  input  wire logic        tf_rd,
  input  wire logic [2:0]  tf_addr,
  input  wire logic [15:0] tf_wdata,
  output logic      [15:0] tf_rdata,
  output logic             intrq,
  output logic             dmarq,
  input  wire logic        dmack,
  input  wire logic [15:0] dma_wdata,
  output logic      [15:0] dma_rdata,
  output logic             sec_start,
  output logic             sec_send,
  output logic      [7:0]  sec_protocol,
  output logic      [23:0] sec_args,
  input  wire logic [15:0] sec_rx_data,
  input  wire logic        sec_rx_valid,
  output logic             sec_rx_ready,
  output logic      [15:0] sec_tx_data,
  output logic             sec_tx_valid,
  input  wire logic        sec_tx_ready
);
  spb_state_t  state_reg, state_next;
  logic [7:0]  feat_reg, feat_next, cnt_reg, cnt_next;
  logic [7:0]  snum_reg, snum_next, clo_reg, clo_next, chi_reg, chi_next;
  logic [7:0]  err_reg, err_next;
  logic [15:0] left_reg, left_next, rdata_reg, rdata_next;
  logic [15:0] rxw_reg, rxw_next;
  logic [7:0]  ptr_reg, ptr_next, proto_reg, proto_next;
  logic [23:0] args_reg, args_next;
  logic        dma_reg, dma_next, bufm_reg, bufm_next, drq_reg, drq_next;
  logic        dmarq_reg, dmarq_next, intrq_reg, intrq_next;
  logic        rxf_reg, rxf_next, rxr_reg, rxr_next;
  logic        start_reg, start_next, send_reg, send_next;
  logic        cmd_go, proto_ok, pio_wr, pio_rd, dma_wr, dma_rd, take;
  logic        rx_acc, fifo_pop, gate, finish, abort;
  logic [1:0]  level_nx;
  logic [7:0]  status;
  logic [15:0] buf_mem [SECTOR_WORDS];
  spb_fifo_if  fq ();

  spb_fifo2 u_fifo (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .f       (fq)
  );

  // Word strobes on both data paths
  assign cmd_go   = tf_wr && tf_addr == TF_CMDST && state_reg == ST_IDLE;
  assign proto_ok = feat_reg <= SEC_PROTO_MAX && cnt_reg != 8'h00; // [RULE14]
  assign pio_wr   = tf_wr && tf_addr == TF_DATA && drq_reg &&
                    state_reg == ST_DIN;                            // [RULE2]
  assign pio_rd   = tf_rd && tf_addr == TF_DATA && drq_reg &&
                    state_reg == ST_DOUT;
  assign dma_wr   = dmarq_reg && dmack && state_reg == ST_DIN;     // [RULE6]
  assign dma_rd   = dmarq_reg && dmack && state_reg == ST_DOUT;    // [RULE6]
  assign take     = pio_wr || pio_rd || dma_wr || dma_rd;
  assign rx_acc   = sec_rx_valid && rxr_reg;
  assign fifo_pop = fq.out_valid && sec_tx_ready;

  // Words into the buffer toward the protocol engine
  assign fq.in_valid  = (pio_wr || dma_wr) && !bufm_reg;           // [RULE3]
  assign fq.in_data   = dma_wr ? dma_wdata : tf_wdata;
  assign fq.out_ready = sec_tx_ready;

  // Status byte built from sequencer state
  always_comb begin
    status = 8'h00;
    status[ST_BSY_BIT] = state_reg != ST_IDLE && !drq_reg;
    status[ST_RDY_BIT] = !status[ST_BSY_BIT];
    status[ST_DRQ_BIT] = drq_reg;
    status[ST_ERR_BIT] = err_reg[ER_ABT_BIT];                      // [RULE10]
  end

  // Command sequencer, word counting and handshakes
  always_comb begin
    state_next = state_reg;
    feat_next  = feat_reg;
    cnt_next   = cnt_reg;
    snum_next  = snum_reg;
    clo_next   = clo_reg;
    chi_next   = chi_reg;
    err_next   = err_reg;
    dma_next   = dma_reg;
    bufm_next  = bufm_reg;
    proto_next = proto_reg;
    args_next  = args_reg;
    send_next  = send_reg;
    start_next = 1'b0;
    finish     = 1'b0;
    abort      = 1'b0;
    left_next  = left_reg - {15'h0000, take};
    ptr_next   = ptr_reg + {7'h00, bufm_reg && (pio_wr || pio_rd)};
    level_nx   = fq.level + {1'b0, fq.in_valid} - {1'b0, fifo_pop};
    // Parameter registers; device/head and data carry none
    if (tf_wr && state_reg == ST_IDLE) begin                       // [RULE8]
      case (tf_addr)
        TF_ERRFT:  feat_next = tf_wdata[7:0];
        TF_COUNT:  cnt_next  = tf_wdata[7:0];
        TF_SECNUM: snum_next = tf_wdata[7:0];
        TF_CYLLO:  clo_next  = tf_wdata[7:0];
        TF_CYLHI:  chi_next  = tf_wdata[7:0];
        default:   feat_next = feat_reg;
      endcase
    end
    case (state_reg)
      ST_IDLE: begin
        if (cmd_go) begin
          err_next  = ERR_RESET;
          left_next = {cnt_reg, 8'h00};
          bufm_next = 1'b0;
          case (tf_wdata[7:0])
            OP_SEC_RX_DMA: begin                                  // [RULE1]
              state_next = ST_DOUT;
              dma_next   = 1'b1;
              send_next  = 1'b0;
            end
            OP_SEC_TX_PIO: begin                                  // [RULE2]
              state_next = ST_DIN;
              dma_next   = 1'b0;
              send_next  = 1'b1;
            end
            OP_SEC_TX_DMA: begin                                  // [RULE3]
              state_next = ST_DIN;
              dma_next   = 1'b1;
              send_next  = 1'b1;
            end
            OP_BUF_LOAD, OP_BUF_READ: begin                        // [RULE11]
              state_next = tf_wdata[2] ? ST_DOUT : ST_DIN;
              dma_next   = 1'b0;
              bufm_next  = 1'b1;
              left_next  = SECTOR_WORDS;
            end
            default: abort = 1'b1;
          endcase
          if (!bufm_next && !abort) begin
            if (proto_ok) begin
              start_next = 1'b1;                                  // [RULE13]
              proto_next = feat_reg;                               // [RULE4]
              args_next  = {chi_reg, clo_reg, snum_reg};
            end else begin
              abort = 1'b1;                                       // [RULE14]
            end
          end
          if (abort) begin
            state_next = ST_IDLE;
            err_next   = 8'h00;
            err_next[ER_ABT_BIT] = 1'b1;                           // [RULE10]
          end
        end
      end
      ST_DIN: begin
        if (left_next == 16'h0000) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DOUT: begin
        if (left_next == 16'h0000) begin
          finish = 1'b1;
        end
      end
      ST_DRAIN: begin
        if (level_nx == 2'h0) begin
          finish = 1'b1;                                          // [RULE7]
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (finish) begin
      state_next = ST_IDLE;
    end
  end

  // Receive slot, request lines, read data and interrupt
  always_comb begin
    rxf_next = (rxf_reg && !dma_rd) || rx_acc;
    rxw_next = rx_acc ? sec_rx_data : rxw_reg;
    rxr_next = state_next == ST_DOUT && !bufm_next && !rxf_next &&
               left_next != 16'h0000;
    gate     = left_next != 16'h0000 && level_nx < FIFO_DEPTH;
    dmarq_next = dma_next && ((state_next == ST_DIN && gate) ||
                 (state_next == ST_DOUT && rxf_next));            // [RULE6]
    drq_next = !dma_next && ((state_next == ST_DIN && gate) ||
               (state_next == ST_DOUT && left_next != 16'h0000));
    rdata_next = 16'h0000;                                        // [RULE9]
    if (tf_rd) begin
      case (tf_addr)
        TF_DATA:  rdata_next = pio_rd ? buf_mem[ptr_reg] : 16'h0000;
        TF_ERRFT: rdata_next = {8'h00, err_reg};
        TF_CMDST: rdata_next = {8'h00, status};
        default:  rdata_next = 16'h0000;
      endcase
    end
    // Completion sets, status read or new command clears; set wins
    intrq_next = finish || abort ||
                 (intrq_reg && !cmd_go && !(tf_rd && tf_addr == TF_CMDST));
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      feat_reg  <= 8'h00;
      cnt_reg   <= 8'h00;
      snum_reg  <= 8'h00;
      clo_reg   <= 8'h00;
      chi_reg   <= 8'h00;
      err_reg   <= ERR_RESET;
      left_reg  <= 16'h0000;
      ptr_reg   <= 8'h00;
      dma_reg   <= 1'b0;
      bufm_reg  <= 1'b0;
      drq_reg   <= 1'b0;
      dmarq_reg <= 1'b0;
      intrq_reg <= 1'b0;
      rxf_reg   <= 1'b0;
      rxr_reg   <= 1'b0;
      rxw_reg   <= 16'h0000;
      rdata_reg <= 16'h0000;
      start_reg <= 1'b0;
      send_reg  <= 1'b0;
      proto_reg <= 8'h00;
      args_reg  <= 24'h000000;
    end else begin
      state_reg <= state_next;
      feat_reg  <= feat_next;
      cnt_reg   <= cnt_next;
      snum_reg  <= snum_next;
      clo_reg   <= clo_next;
      chi_reg   <= chi_next;
      err_reg   <= err_next;
      left_reg  <= left_next;
      ptr_reg   <= (cmd_go && bufm_next) ? 8'h00 : ptr_next;  // [RULE12]
      dma_reg   <= dma_next;
      bufm_reg  <= bufm_next;
      drq_reg   <= drq_next;
      dmarq_reg <= dmarq_next;
      intrq_reg <= intrq_next;
      rxf_reg   <= rxf_next;
      rxr_reg   <= rxr_next;
      rxw_reg   <= rxw_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      send_reg  <= send_next;
      proto_reg <= proto_next;
      args_reg  <= args_next;
    end
  end

  // Sector buffer write port
  always_ff @(posedge sys_clk) begin
    if (pio_wr && bufm_reg) begin
      buf_mem[ptr_reg] <= tf_wdata;                               // [RULE11]
    end
  end

  assign tf_rdata     = rdata_reg;
  assign intrq        = intrq_reg;
  assign dmarq        = dmarq_reg;
  assign dma_rdata    = rxw_reg;
  assign sec_rx_ready = rxr_reg;
  assign sec_start    = start_reg;
  assign sec_send     = send_reg;
  assign sec_protocol = proto_reg;
  assign sec_args     = args_reg;
  assign sec_tx_data  = fq.out_data;
  assign sec_tx_valid = fq.out_valid;

  // Checks
  intr_after_end_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $rose(intrq_reg) |-> state_reg == ST_IDLE && !drq_reg && !dmarq_reg)
    else $error("interrupt raised before transfer ended"); // [RULE7]
  done_status_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg == ST_IDLE |-> (status & 8'he6) == 8'h40)
    else $error("idle status bits wrong"); // [RULE10]
  error_bits_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (err_reg & 8'hfb) == 8'h00 && err_reg[2] == status[0])
    else $error("error register holds more than abort"); // [RULE10]
  dmarq_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    dmarq_reg |-> dma_reg && !drq_reg && state_reg != ST_IDLE)
    else $error("dma request outside dma command"); // [RULE6]
  recv_start_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_go && tf_wdata[7:0] == OP_SEC_RX_DMA && proto_ok
    |=> state_reg == ST_DOUT && dma_reg && sec_start)
    else $error("receive dma command not started"); // [RULE1]
  bad_proto_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_go && tf_wdata[7:0] == OP_SEC_TX_DMA && !proto_ok
    |=> state_reg == ST_IDLE && err_reg == 8'h04 && intrq_reg && !sec_start)
    else $error("bad protocol not aborted"); // [RULE14]
  proto_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    sec_start |-> sec_protocol == $past(feat_reg))
    else $error("protocol does not follow feature"); // [RULE4]
  buf_region_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cmd_go && (tf_wdata[7:0] == OP_BUF_LOAD || tf_wdata[7:0] == OP_BUF_READ)
    |=> ptr_reg == 8'h00 && left_reg == SECTOR_WORDS && drq_reg)
    else $error("buffer command not at region start"); // [RULE12]
  pio_push_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    pio_wr && !bufm_reg |-> fq.in_valid && fq.in_ready)
    else $error("pio word lost"); // [RULE2]
endmodule // spb_cmd_top

// >>> verilog/spb_fifo2.sv
// Two-entry word buffer with valid and ready on both sides
`timescale 1ns/1ps
module spb_fifo2 import spb_pkg::*; (
  input wire logic sys_clk,
  input wire logic sys_rst,
  spb_fifo_if.store f
);
  logic [15:0] head_reg, head_next, tail_reg, tail_next;
  logic        v0_reg, v0_next, v1_reg, v1_next;
  logic        push, pop;

  // Pop from head, push into first free slot
  always_comb begin
    push      = f.in_valid && !v1_reg;
    pop       = v0_reg && f.out_ready;
    head_next = head_reg;
    tail_next = tail_reg;
    v0_next   = v0_reg;
    v1_next   = v1_reg;
    if (pop) begin
      head_next = tail_reg;
      v0_next   = v1_reg;
      v1_next   = 1'b0;
    end
    if (push) begin
      if (!v0_next) begin
        head_next = f.in_data;
        v0_next   = 1'b1;
      end else begin
        tail_next = f.in_data;
        v1_next   = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      head_reg <= 16'h0000;
      tail_reg <= 16'h0000;
      v0_reg   <= 1'b0;
      v1_reg   <= 1'b0;
    end else begin
      head_reg <= head_next;
      tail_reg <= tail_next;
      v0_reg   <= v0_next;
      v1_reg   <= v1_next;
    end
  end

  // Flags straight from the valid flops
  assign f.in_ready  = !v1_reg;
  assign f.out_valid = v0_reg;
  assign f.out_data  = head_reg;
  assign f.level     = {v1_reg, v0_reg & ~v1_reg};
endmodule // spb_fifo2

// >>> verilog/spb_fifo_if.sv
// Carrier for the two-entry word buffer between sequencer and buffer
`timescale 1ns/1ps
interface spb_fifo_if;
  logic [15:0] in_data;
  logic        in_valid;
  logic        in_ready;
  logic [15:0] out_data;
  logic        out_valid;
  logic        out_ready;
  logic [1:0]  level;
  modport store (input in_data, in_valid, out_ready,
                 output in_ready, out_data, out_valid, level);
  modport user  (output in_data, in_valid, out_ready,
                 input in_ready, out_data, out_valid, level);
endinterface

// >>> verilog/spb_pkg.sv
// Constants and types for the security packet and buffer load command block
// Behaviour
// RULE1: Command 5Dh returns 512-byte packets to the host over DMA.
// RULE2: Command 5Eh takes packets by PIO, one 16-bit word per data write.
// RULE3: Command 5Fh accepts packets from the host over DMA.
// RULE4: Feature register selects the security protocol of sent packets.
// RULE5: Host sets up its slave-DMA channel before a DMA packet command.
// RULE6: Each DMA word is qualified by DMARQ; host DMA does the move.
// RULE7: One interrupt per DMA packet command, after transfer and status.
// RULE8: Parameters come in feature, count, sector, cylinder registers only.
// RULE9: After a packet command only error and status carry results.
// RULE10: Completion shows BSY, DF, CORR, IDX zero; only abort bit in error.
// RULE11: Command E8h loads one sector of 16-bit words into the buffer.
// RULE12: Buffer load and buffer read use the same 512-byte region.
// RULE13: Accepted packets are interpreted per the selected protocol.
// RULE14: Unsupported protocol or bad parameters abort with no data moved.
package spb_pkg;
  // Taskfile register addresses
  localparam logic [2:0] TF_DATA   = 3'h0;
  localparam logic [2:0] TF_ERRFT  = 3'h1;
  localparam logic [2:0] TF_COUNT  = 3'h2;
  localparam logic [2:0] TF_SECNUM = 3'h3;
  localparam logic [2:0] TF_CYLLO  = 3'h4;
  localparam logic [2:0] TF_CYLHI  = 3'h5;
  localparam logic [2:0] TF_CMDST  = 3'h7;
  // Command opcodes
  localparam logic [7:0] OP_SEC_RX_DMA = 8'h5d;
  localparam logic [7:0] OP_SEC_TX_PIO = 8'h5e;
  localparam logic [7:0] OP_SEC_TX_DMA = 8'h5f;
  localparam logic [7:0] OP_BUF_LOAD   = 8'he8;
  localparam logic [7:0] OP_BUF_READ   = 8'he4;
  // Status and error bit positions
  localparam int ST_BSY_BIT = 7;
  localparam int ST_RDY_BIT = 6;
  localparam int ST_DRQ_BIT = 3;
  localparam int ST_ERR_BIT = 0;
  localparam int ER_ABT_BIT = 2;
  // Reset values and sizes
  localparam logic [7:0]  ERR_RESET    = 8'h00;
  localparam logic [7:0]  SEC_PROTO_MAX = 8'h02;
  localparam logic [15:0] SECTOR_WORDS = 16'h0100;
  localparam logic [1:0]  FIFO_DEPTH   = 2'h2;
  // Command sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_DIN, ST_DOUT, ST_DRAIN} spb_state_t;
endpackage
